// ===== src/ch7_cal_regs.sv
// APB register bank for channel 7 configuration and calibration
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module ch7_cal_regs #(
  parameter int PHASE_W = 10
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device-wide filter setting
  input  wire logic        global_dc_block_setting,
  // Modulator sample strobe and conversion results
  input  wire logic        mod_tick,
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  // Channel controls
  output logic             sample_strobe,
  output logic             route_pins,
  output logic             route_short,
  output logic             route_test_pos,
  output logic             route_test_neg,
  output logic             dc_block_enable,
  output ch7_cal_pkg::ch_cfg_t settings,
  output logic             cal_valid,
  output logic [23:0]      cal_data
);
  logic [15:0]           cfg_ff;
  logic [15:0]           ofs_up_ff;
  logic [15:0]           ofs_lo_ff;
  logic [15:0]           gain_up_ff;
  logic [15:0]           gain_lo_ff;
  logic [PHASE_W:0]      phase_cnt_ff;
  logic                  armed_ff;
  logic                  wr_en;
  logic                  rd_en;
  logic [7:0]            idx;
  logic                  hit;
  logic [15:0]           nxt_rdata;
  logic signed [PHASE_W:0] nxt_wait;

  // Decide whether a register index is a mapped register
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == ch7_cal_pkg::IDX_CFG) || (i == ch7_cal_pkg::IDX_OFS_UP) ||
             (i == ch7_cal_pkg::IDX_OFS_LO) || (i == ch7_cal_pkg::IDX_GAIN_UP) ||
             (i == ch7_cal_pkg::IDX_GAIN_LO);
  endfunction

  // Zero wait state slave; unmapped or misaligned access errors
  assign idx     = paddr[ch7_cal_pkg::ADDR_LSB +: ch7_cal_pkg::IDX_W];
  assign hit     = mapped(idx) && (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign rd_en   = psel & ~penable & ~pwrite;

  // Configuration word, reserved bits 5:3 forced to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= ch7_cal_pkg::RST_CFG;
    end else if (wr_en && idx == ch7_cal_pkg::IDX_CFG) begin
      cfg_ff <= pwdata[15:0] & ch7_cal_pkg::CFG_MASK;
    end
  end

  // Offset words; low byte of the lower word is reserved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofs_up_ff <= ch7_cal_pkg::RST_ZERO;
      ofs_lo_ff <= ch7_cal_pkg::RST_ZERO;
    end else if (wr_en) begin
      if (idx == ch7_cal_pkg::IDX_OFS_UP) begin
        ofs_up_ff <= pwdata[15:0];
      end
      if (idx == ch7_cal_pkg::IDX_OFS_LO) begin
        ofs_lo_ff <= pwdata[15:0] & ch7_cal_pkg::LO_MASK;
      end
    end
  end

  // Gain words; reset gives unity gain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_up_ff <= ch7_cal_pkg::RST_GAIN_UP;
      gain_lo_ff <= ch7_cal_pkg::RST_ZERO;
    end else if (wr_en) begin
      if (idx == ch7_cal_pkg::IDX_GAIN_UP) begin
        gain_up_ff <= pwdata[15:0];
      end
      if (idx == ch7_cal_pkg::IDX_GAIN_LO) begin
        gain_lo_ff <= pwdata[15:0] & ch7_cal_pkg::LO_MASK;
      end
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    case (idx)
      ch7_cal_pkg::IDX_CFG:     nxt_rdata = cfg_ff;
      ch7_cal_pkg::IDX_OFS_UP:  nxt_rdata = ofs_up_ff;
      ch7_cal_pkg::IDX_OFS_LO:  nxt_rdata = ofs_lo_ff;
      ch7_cal_pkg::IDX_GAIN_UP: nxt_rdata = gain_up_ff;
      ch7_cal_pkg::IDX_GAIN_LO: nxt_rdata = gain_lo_ff;
      default:                  nxt_rdata = 16'h0000;
    endcase
  end

  // Read data captured in the setup cycle, so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= hit ? {16'h0000, nxt_rdata} : 32'h0000_0000; // Refused reads give zero
    end
  end

  // Settings bundle assembled from the register words
  always_comb begin
    settings.ch_phase_delay     = cfg_ff[ch7_cal_pkg::PHASE_HI:ch7_cal_pkg::PHASE_LO];
    settings.ch_dc_block_bypass = cfg_ff[ch7_cal_pkg::BYPASS_BIT];
    settings.ch_input_select    = ch7_cal_pkg::input_sel_t'(cfg_ff[ch7_cal_pkg::SEL_HI:ch7_cal_pkg::SEL_LO]);
    settings.offset_corr        = {ofs_up_ff, ofs_lo_ff[15:8]};
    settings.gain_corr          = {gain_up_ff, gain_lo_ff[15:8]};
  end

  // Phase delay: the signed value is biased so zero sits mid-range, giving
  // every channel a common latency and a negative delay a meaningful lead
  assign nxt_wait = $signed({settings.ch_phase_delay[PHASE_W-1], settings.ch_phase_delay}) +
                    $signed((PHASE_W+1)'(1 << (PHASE_W-1)));

  // Delay counter in modulator ticks, restarted on each raw result strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt_ff  <= '0;
      armed_ff      <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      if (raw_valid) begin
        phase_cnt_ff <= nxt_wait[PHASE_W:0];
        armed_ff     <= 1'b1;
      end else if (armed_ff && mod_tick) begin
        if (phase_cnt_ff == '0) begin
          sample_strobe <= 1'b1;
          armed_ff      <= 1'b0;
        end else begin
          phase_cnt_ff <= phase_cnt_ff - 1'b1;
        end
      end
    end
  end

  ch7_input_route u_route (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .ch_input_select         (settings.ch_input_select),
    .ch_dc_block_bypass      (settings.ch_dc_block_bypass),
    .global_dc_block_setting (global_dc_block_setting),
    .route_pins              (route_pins),
    .route_short             (route_short),
    .route_test_pos          (route_test_pos),
    .route_test_neg          (route_test_neg),
    .dc_block_enable         (dc_block_enable)
  );

  ch7_cal_datapath #(
    .W (ch7_cal_pkg::DATA_W)
  ) u_cal (
    .pclk        (pclk),
    .presetn     (presetn),
    .offset_corr (settings.offset_corr),
    .gain_corr   (settings.gain_corr),
    .raw_valid   (raw_valid),
    .raw_data    (raw_data),
    .cal_valid   (cal_valid),
    .cal_data    (cal_data)
  );

  // Reserved configuration bits always read zero
  a_cfg_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff[5:3] == 3'h0) else $error("config reserved bits nonzero");
  // Configuration write keeps only the writable fields
  a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == ch7_cal_pkg::IDX_CFG) |=> cfg_ff == ($past(pwdata[15:0]) & ch7_cal_pkg::CFG_MASK))
    else $error("config write lost");
  // Lower offset reserved byte reads zero
  a_ofs_lo_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    ofs_lo_ff[7:0] == 8'h00) else $error("offset low reserved nonzero");
  // Lower offset write keeps its high byte only
  a_ofs_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == ch7_cal_pkg::IDX_OFS_LO) |=> ofs_lo_ff == ($past(pwdata[15:0]) & ch7_cal_pkg::LO_MASK))
    else $error("offset lower write lost");
  // Lower gain reserved byte reads zero
  a_gain_lo_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    gain_lo_ff[7:0] == 8'h00) else $error("gain low reserved nonzero");
  // Lower gain write keeps its high byte only
  a_gain_lo_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == ch7_cal_pkg::IDX_GAIN_LO) |=> gain_lo_ff == ($past(pwdata[15:0]) & ch7_cal_pkg::LO_MASK))
    else $error("gain lower write lost");
  // Upper offset write lands one cycle later
  a_ofs_up_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == ch7_cal_pkg::IDX_OFS_UP) |=> ofs_up_ff == $past(pwdata[15:0]))
    else $error("offset upper write lost");
  // Upper gain write lands one cycle later
  a_gain_up_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == ch7_cal_pkg::IDX_GAIN_UP) |=> gain_up_ff == $past(pwdata[15:0]))
    else $error("gain upper write lost");
  // Bypass kills the DC block two cycles on
  a_bypass_dc: assert property (@(posedge pclk) disable iff (!presetn)
    settings.ch_dc_block_bypass ##1 settings.ch_dc_block_bypass |=> !dc_block_enable)
    else $error("dc block not bypassed");
  // Without bypass the device-wide setting passes through
  a_dc_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !settings.ch_dc_block_bypass |=> dc_block_enable == $past(global_dc_block_setting))
    else $error("dc block ignores global setting");
  // Own pins selected drives only the pin switch
  a_pins_route: assert property (@(posedge pclk) disable iff (!presetn)
    settings.ch_input_select == ch7_cal_pkg::SEL_PINS |=> route_pins && !route_short)
    else $error("pin routing wrong");
  // Shorted select drives only the short switch
  a_short_route: assert property (@(posedge pclk) disable iff (!presetn)
    settings.ch_input_select == ch7_cal_pkg::SEL_SHORT |=> route_short && !route_pins)
    else $error("short routing wrong");
  // Positive test select drives only its switch
  a_pos_route: assert property (@(posedge pclk) disable iff (!presetn)
    settings.ch_input_select == ch7_cal_pkg::SEL_TEST_P |=> route_test_pos && !route_test_neg)
    else $error("positive test routing wrong");
  // Negative test select drives only its switch
  a_neg_route: assert property (@(posedge pclk) disable iff (!presetn)
    settings.ch_input_select == ch7_cal_pkg::SEL_TEST_N |=> route_test_neg && !route_test_pos)
    else $error("test routing wrong");
  // Two closed switches would short the front end
  a_route_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot({route_pins, route_short, route_test_pos, route_test_neg}))
    else $error("input switches overlap");
  // Zero offset, unity gain passes data through
  a_unity_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (raw_valid && settings.offset_corr == 24'h000000 && settings.gain_corr == 24'h800000)
    |=> cal_valid && cal_data == $past(raw_data)) else $error("unity path altered");
  // Result strobe follows the raw strobe by one cycle
  a_cal_valid_rise: assert property (@(posedge pclk) disable iff (!presetn)
    raw_valid |=> cal_valid) else $error("corrected result missing");
  // No result without a raw strobe
  a_cal_valid_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !raw_valid |=> !cal_valid) else $error("spurious corrected result");
  // Sampling strobe lasts a single cycle
  a_strobe_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    sample_strobe |=> !sample_strobe) else $error("sampling strobe stuck");
  // Unmapped access answers with an error
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped(idx)) |-> pslverr) else $error("unmapped not flagged");
  // Refused reads leak no register contents
  a_read_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && !hit) |=> prdata == 32'h0000_0000)
    else $error("refused read returned data");
endmodule

// ===== src/ch7_cal_pkg.sv
// Constants and types for the channel 7 configuration and calibration bank
// How it works
// - Phase delay: signed 10 bits at 15:6
// - Bit 2 set bypasses DC block here
// - Select 00 own pins, 01 shorted
// - Select 10 positive, 11 negative test
// - Upper offset register holds offset 23:8
// - Lower offset 15:8 holds 7:0, rest zero
// - Offset is signed two's complement
// - Upper gain register holds gain 23:8
// - Lower gain 15:8 holds 7:0, rest zero
// - Gain unsigned, one at 8000h upper
// - Reset: gain upper 8000h, others zero
package ch7_cal_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG      = 8'h2C;
  localparam logic [7:0] IDX_OFS_UP   = 8'h2D;
  localparam logic [7:0] IDX_OFS_LO   = 8'h2E;
  localparam logic [7:0] IDX_GAIN_UP  = 8'h2F;
  localparam logic [7:0] IDX_GAIN_LO  = 8'h30;
  localparam int         ADDR_LSB     = 2;
  localparam int         IDX_W        = 8;
  // Field layout
  localparam int         PHASE_HI     = 15;
  localparam int         PHASE_LO     = 6;
  localparam int         PHASE_W      = 10;
  localparam int         BYPASS_BIT   = 2;
  localparam int         SEL_HI       = 1;
  localparam int         SEL_LO       = 0;
  localparam int         REG_W        = 16;
  localparam int         DATA_W       = 24;
  localparam int         GAIN_FRAC    = 23;
  // Reset values and masks
  localparam logic [15:0] RST_CFG     = 16'h0000;
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  localparam logic [15:0] RST_GAIN_UP = 16'h8000;
  localparam logic [15:0] CFG_MASK    = 16'hFFC7;
  localparam logic [15:0] LO_MASK     = 16'hFF00;
  // Input selection codes
  typedef enum logic [1:0] {
    SEL_PINS    = 2'h0,
    SEL_SHORT   = 2'h1,
    SEL_TEST_P  = 2'h2,
    SEL_TEST_N  = 2'h3
  } input_sel_t;
  // Settings bundle handed to the channel datapath
  typedef struct packed {
    logic [9:0]  ch_phase_delay;
    logic        ch_dc_block_bypass;
    input_sel_t  ch_input_select;
    logic [23:0] offset_corr;
    logic [23:0] gain_corr;
  } ch_cfg_t;
endpackage

// ===== src/ch7_cal_datapath.sv
// Offset and gain correction of one conversion result
`timescale 1ns/10ps
module ch7_cal_datapath #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Settings
  input  wire logic [W-1:0] offset_corr,
  input  wire logic [W-1:0] gain_corr,
  // Raw result in, corrected result out
  input  wire logic         raw_valid,
  input  wire logic [W-1:0] raw_data,
  output logic              cal_valid,
  output logic [W-1:0]      cal_data
);
  localparam logic signed [W+1:0] MAX_V = (W+2)'((1 <<< (W-1)) - 1);
  localparam logic signed [W+1:0] MIN_V = -(W+2)'(1 <<< (W-1));
  logic signed [W:0]       nxt_sum;
  logic signed [2*W+1:0]   nxt_prod;
  logic signed [W+1:0]     nxt_scaled;
  logic [W-1:0]            nxt_cal;
  // Signed offset added first, then unsigned gain with 23 fraction bits
  always_comb begin
    nxt_sum    = $signed({raw_data[W-1], raw_data}) + $signed({offset_corr[W-1], offset_corr});
    nxt_prod   = nxt_sum * $signed({1'b0, gain_corr});
    nxt_scaled = nxt_prod[ch7_cal_pkg::GAIN_FRAC +: W+2];
    // Clamp to the signed output range rather than wrap
    if (nxt_scaled > MAX_V) begin
      nxt_cal = MAX_V[W-1:0];
    end else if (nxt_scaled < MIN_V) begin
      nxt_cal = MIN_V[W-1:0];
    end else begin
      nxt_cal = nxt_scaled[W-1:0];
    end
  end
  // Registered output, one cycle after the raw strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_valid <= 1'b0;
      cal_data  <= '0;
    end else begin
      cal_valid <= raw_valid;
      if (raw_valid) begin
        cal_data <= nxt_cal;
      end
    end
  end
endmodule

// ===== src/ch7_input_route.sv
// Input selection decode for the channel front end
`timescale 1ns/10ps
module ch7_input_route (
  // Selection and global filter setting
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  ch7_cal_pkg::input_sel_t      ch_input_select,
  input  wire logic                    ch_dc_block_bypass,
  input  wire logic                    global_dc_block_setting,
  // Analog switch controls, registered to avoid glitches
  output logic                         route_pins,
  output logic                         route_short,
  output logic                         route_test_pos,
  output logic                         route_test_neg,
  output logic                         dc_block_enable
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_pins      <= 1'b1;
      route_short     <= 1'b0;
      route_test_pos  <= 1'b0;
      route_test_neg  <= 1'b0;
      dc_block_enable <= 1'b0;
    end else begin
      route_pins      <= (ch_input_select == ch7_cal_pkg::SEL_PINS);
      route_short     <= (ch_input_select == ch7_cal_pkg::SEL_SHORT);
      route_test_pos  <= (ch_input_select == ch7_cal_pkg::SEL_TEST_P);
      route_test_neg  <= (ch_input_select == ch7_cal_pkg::SEL_TEST_N);
      dc_block_enable <= global_dc_block_setting & ~ch_dc_block_bypass;
    end
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the channel 7 calibration register bank
`timescale 1ns/10ps
module tb;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 global_dc_block_setting;
  logic                 mod_tick;
  logic                 raw_valid;
  logic [23:0]          raw_data;
  logic                 sample_strobe;
  logic [3:0]           route;
  logic                 dc_block_enable;
  ch7_cal_pkg::ch_cfg_t settings;
  logic                 cal_valid;
  logic [23:0]          cal_data;
  int                   n_errors;
  int                   checked;
  logic [31:0]          rd;
  logic                 err;
  logic [7:0]           idx_tab [5];

  ch7_cal_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_dc_block_setting(global_dc_block_setting), .mod_tick(mod_tick),
    .raw_valid(raw_valid), .raw_data(raw_data), .sample_strobe(sample_strobe),
    .route_pins(route[3]), .route_short(route[2]), .route_test_pos(route[1]),
    .route_test_neg(route[0]), .dc_block_enable(dc_block_enable), .settings(settings),
    .cal_valid(cal_valid), .cal_data(cal_data)
  );

  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Shared comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Byte address is four times the register index
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, {16'hA5A5, d});
  endtask

  task automatic rd_expect(input logic [7:0] idx, input logic [15:0] exp);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    check(rd, {16'h0000, exp});
    check({31'h0, err}, 32'h0);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Reset contents and channel controls
  task automatic t_reset();
    logic [15:0] exp [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    for (int i = 0; i < 5; i++) rd_expect(idx_tab[i], exp[i]);
    check({28'h0, route}, 32'h8);
    check(settings.gain_corr, 24'h800000);
  endtask

  // Unmapped, misaligned and out-of-range accesses are refused
  task automatic t_refuse();
    apb(1'b1, {2'b00, 8'h31, 2'b00}, 32'hFFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b1, {2'b00, ch7_cal_pkg::IDX_GAIN_UP, 2'b01}, 32'h1234);
    check({31'h0, err}, 32'h1);
    apb(1'b0, {2'b10, ch7_cal_pkg::IDX_GAIN_UP, 2'b00}, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    rd_expect(ch7_cal_pkg::IDX_GAIN_UP, 16'h8000);
  endtask

  // Reserved bits read zero; fields pair into 24-bit words; reset mid-run
  task automatic t_fields();
    logic [15:0] msk [5] = '{16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};
    for (int i = 0; i < 5; i++) wr_reg(idx_tab[i], 16'hFFFF);
    for (int i = 0; i < 5; i++) rd_expect(idx_tab[i], msk[i]);
    wr_reg(ch7_cal_pkg::IDX_OFS_UP, 16'h1234);
    wr_reg(ch7_cal_pkg::IDX_OFS_LO, 16'h56AB);
    wr_reg(ch7_cal_pkg::IDX_GAIN_UP, 16'hABCD);
    wr_reg(ch7_cal_pkg::IDX_GAIN_LO, 16'hEF12);
    #1; // Last write lands at the edge the task returns on
    check(settings.offset_corr, 24'h123456);
    check(settings.gain_corr, 24'hABCDEF);
    do_reset();
    for (int i = 0; i < 5; i++) rd_expect(idx_tab[i], (i == 3) ? 16'h8000 : 16'h0000);
  endtask

  // Every select code against every bypass and global setting
  task automatic t_route();
    logic [3:0] k;
    logic [9:0] ph;
    for (int j = 0; j < 16; j++) begin
      k = 4'(j);
      ph = 10'(j * 67 + 300);
      @(posedge pclk);
      global_dc_block_setting <= k[3];
      wr_reg(ch7_cal_pkg::IDX_CFG, {ph, 3'b111, k[2:0]});
      repeat (2) @(posedge pclk);
      #1;
      check({28'h0, route}, 32'h8 >> k[1:0]);
      check({31'h0, dc_block_enable}, {31'h0, k[3] & ~k[2]});
      check({20'h0, settings.ch_phase_delay, 2'(settings.ch_input_select)}, {20'h0, ph, k[1:0]});
      rd_expect(ch7_cal_pkg::IDX_CFG, {ph, 3'b000, k[2:0]});
    end
  endtask

  // Offset first, then gain, saturated to the signed 24-bit range
  function automatic logic [23:0] model(input logic [23:0] raw, input logic [23:0] off, input logic [23:0] g);
    longint s;
    s = (longint'($signed(raw)) + longint'($signed(off))) * longint'({40'h0, g});
    s = s >>> 23;
    if (s > 64'sd8388607) s = 64'sd8388607;
    if (s < -64'sd8388608) s = -64'sd8388608;
    return s[23:0];
  endfunction

  task automatic t_cal();
    logic [23:0] tab [7][3] = '{'{24'h000100, 24'h000000, 24'h800000}, '{24'h000100, 24'hFFFFF0, 24'h800000},
      '{24'h001000, 24'h000000, 24'h400000}, '{24'h700000, 24'h200000, 24'h800000},
      '{24'h900000, 24'hE00000, 24'h800000}, '{24'h400000, 24'h000000, 24'hFFFF00},
      '{24'h123456, 24'h000010, 24'h000000}};
    for (int i = 0; i < 7; i++) begin
      wr_reg(ch7_cal_pkg::IDX_OFS_UP, tab[i][1][23:8]);
      wr_reg(ch7_cal_pkg::IDX_OFS_LO, {tab[i][1][7:0], 8'h00});
      wr_reg(ch7_cal_pkg::IDX_GAIN_UP, tab[i][2][23:8]);
      wr_reg(ch7_cal_pkg::IDX_GAIN_LO, {tab[i][2][7:0], 8'h00});
      @(posedge pclk);
      raw_valid <= 1'b1;
      raw_data <= tab[i][0];
      @(posedge pclk);
      raw_valid <= 1'b0;
      #1;
      check({7'h0, cal_valid, cal_data}, {8'h01, model(tab[i][0], tab[i][1], tab[i][2])});
      @(posedge pclk);
      #1;
      check({31'h0, cal_valid}, 32'h0);
    end
  endtask

  // Cycles from a result to the delayed sampling strobe, one tick per cycle
  task automatic delay_of(input logic [9:0] ph, output int n);
    wr_reg(ch7_cal_pkg::IDX_CFG, {ph, 6'h00});
    @(posedge pclk);
    mod_tick <= 1'b1;
    raw_valid <= 1'b1;
    @(posedge pclk);
    raw_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (sample_strobe !== 1'b1 && n < 3000);
    @(posedge pclk);
    mod_tick <= 1'b0;
  endtask

  task automatic t_phase();
    int n0;
    int np;
    int nn;
    delay_of(10'h000, n0);
    delay_of(10'h005, np);
    delay_of(10'h3FD, nn);
    check(np - n0, 32'd5);
    check(nn - n0, -32'sd3);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  initial begin
    idx_tab = '{ch7_cal_pkg::IDX_CFG, ch7_cal_pkg::IDX_OFS_UP, ch7_cal_pkg::IDX_OFS_LO,
                ch7_cal_pkg::IDX_GAIN_UP, ch7_cal_pkg::IDX_GAIN_LO};
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {global_dc_block_setting, mod_tick, raw_valid, raw_data} = '0;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refuse();
    t_fields();
    t_route();
    t_cal();
    t_phase();
    summarize();
  end
endmodule
